// *** hdl/sdc_divider.v ***
// Purpose: output divider by 3..6, 50% duty
// Assumes: tick_in marks one vco edge per pulse
// Notes:   odd ratios alternate long and short highs, 50% over two periods
`timescale 1ns/1ps
`include "sdc_regs.vh"
module sdc_divider (
    // clock and reset
    input  wire       sys_clk_in,
    input  wire       clk_en_in,
    input  wire       rst_in,
    // control
    input  wire       hold_in,
    input  wire       tick_in,
    input  wire [1:0] code_in,
    // output
    output reg        div_out
);
    reg  [2:0] cnt_reg;
    reg        ph_reg;
    wire [2:0] ratio = {1'b0, code_in} + 3'h3;
    wire [2:0] high_len = {1'b0, ratio[2:1]} + {2'h0, ratio[0] & ph_reg};
    always @(posedge sys_clk_in) begin
        if (rst_in) begin
            cnt_reg <= 3'h0;
            div_out <= 1'b0;
            ph_reg  <= 1'b0;
        end else if (clk_en_in) begin
            if (hold_in) begin
                cnt_reg <= 3'h0;
                div_out <= 1'b0;
                ph_reg  <= 1'b0;
            end else if (tick_in) begin
                // period parity picks the high length
                if (cnt_reg + 3'h1 >= ratio) begin
                    cnt_reg <= 3'h0;
                    ph_reg  <= ~ph_reg;
                end else begin
                    cnt_reg <= cnt_reg + 3'h1;
                end
                div_out <= (cnt_reg + 3'h1 < ratio) && (cnt_reg + 3'h1 < high_len)
                           || (cnt_reg + 3'h1 >= ratio);
            end
        end
    end
endmodule

// *** hdl/sdc_regs.vh ***
`ifndef SDC_REGS_VH
`define SDC_REGS_VH
// Purpose: constants of the synthesizer configuration loader
// Assumes: 32-bit AHB-Lite word registers
// Notes:   offsets are byte addresses
`define SDC_CTRL_OFS      8'h00
`define SDC_STATUS_OFS    8'h04
`define SDC_CFG_OFS       8'h08
`define SDC_SHIFT_OFS     8'h0c
`define SDC_CTRL_RESET    32'h0000_0001
// control field positions
`define SDC_CTRL_MR       0
`define SDC_CTRL_REFSEL   1
`define SDC_CTRL_BYPASS   2
// config/shift layout: m 8:0, n 10:9, test 12:11
`define SDC_M_LSB         0
`define SDC_M_MSB         8
`define SDC_N_LSB         9
`define SDC_N_MSB         10
`define SDC_T_LSB         11
`define SDC_T_MSB         12
`define SDC_SR_BITS       13
`define SDC_M_BITS        9
`define SDC_N_BITS        2
`define SDC_N_BASE        3
// diagnostic select codes
`define SDC_DIAG_LOW      2'h0
`define SDC_DIAG_SDATA    2'h1
`define SDC_DIAG_FB       2'h2
`define SDC_DIAG_CLK      2'h3
`endif

// *** hdl/sdc_sync.v ***
// Purpose: two-flop synchroniser, one per bit
// Assumes: inputs asynchronous to sys_clk_in
// Notes:   first stage feeds only the second
`timescale 1ns/1ps
module sdc_sync #(
    parameter W = 1
) (
    // clock
    input  wire         sys_clk_in,
    input  wire         clk_en_in,
    // data
    input  wire [W-1:0] d_in,
    output wire [W-1:0] q_out
);
    genvar i;
    generate
        for (i = 0; i < W; i = i + 1) begin : g_bit
            reg s1_reg;
            reg s2_reg;
            always @(posedge sys_clk_in) begin
                if (clk_en_in) begin
                    s1_reg <= d_in[i];
                    s2_reg <= s1_reg;
                end
            end
            assign q_out[i] = s2_reg;
        end
    endgenerate
endmodule

// *** hdl/sdc_top.v ***
// Purpose: configuration loader with AHB-Lite mirror
// Assumes: pins asynchronous, sampled by two flops
// Notes:   vco and reference are modelled as sys_clk ticks
//
// Our own choices: the AHB-Lite slave port and the placing of the registers.
`timescale 1ns/1ps
`include "sdc_regs.vh"
module sdc_top (
    // clock and reset
    input  wire        sys_clk_in,
    input  wire        clk_en_in,
    input  wire        rst_in,
    // configuration pins
    input  wire        divider_reset_in,
    input  wire        parallel_latch_strobe_n_in,
    input  wire [8:0]  feedback_divide_inputs_in,
    input  wire [1:0]  output_divide_inputs_in,
    input  wire        serial_clock_in,
    input  wire        serial_data_in,
    input  wire        serial_load_in,
    input  wire        reference_source_select_in,
    input  wire        pll_bypass_select_in,
    // reference clocks, sampled as data
    input  wire        crystal_input_in,
    input  wire        alt_reference_in,
    // ahb-lite slave
    input  wire        hsel_in,
    input  wire [7:0]  haddr_in,
    input  wire [1:0]  htrans_in,
    input  wire        hwrite_in,
    input  wire [2:0]  hsize_in,
    input  wire [31:0] hwdata_in,
    input  wire        hready_in,
    output reg  [31:0] hrdata_out,
    output reg         hreadyout_out,
    output reg         hresp_out,
    // synthesizer outputs
    output reg         synth_out0_true_out,
    output reg         synth_out0_comp_out,
    output reg         synth_out1_true_out,
    output reg         synth_out1_comp_out,
    output reg         crystal_drive_output_out,
    output reg         diag_out,
    output reg  [8:0]  feedback_divide_out,
    output reg  [1:0]  output_divide_out,
    output reg         diag_select_msb_out,
    output reg         diag_select_lsb_out
);
    localparam SW = 20;
    wire [SW-1:0] raw = {divider_reset_in, parallel_latch_strobe_n_in,
                         feedback_divide_inputs_in, output_divide_inputs_in,
                         serial_clock_in, serial_data_in, serial_load_in,
                         reference_source_select_in, pll_bypass_select_in,
                         crystal_input_in, alt_reference_in};
    wire [SW-1:0] syn;
    // one chain for all pins keeps their relative timing
    sdc_sync #(.W(SW)) u_sync (
        .sys_clk_in (sys_clk_in),
        .clk_en_in  (clk_en_in),
        .d_in       (raw),
        .q_out      (syn)
    );
    wire       mr_pin   = syn[19];
    wire       pl_n     = syn[18];
    wire [8:0] m_pin    = syn[17:9];
    wire [1:0] n_pin    = syn[8:7];
    wire       sclk     = syn[6];
    wire       sdata    = syn[5];
    wire       sload    = syn[4];
    wire       refsel   = syn[3];
    wire       bypass_p = syn[2];
    // reference levels ride the same chain as the selects
    wire       xtal_s   = syn[1];
    wire       alt_s    = syn[0];

    reg        pl_n_d_reg;
    reg        sclk_d_reg;
    reg        sload_d_reg;
    reg [12:0] shift_reg;
    reg [12:0] cfg_reg;
    reg [31:0] ctrl_reg;
    reg        ref_d_reg;
    reg [8:0]  fb_cnt_reg;
    reg        fb_out_reg;

    wire pl_rise  = pl_n & ~pl_n_d_reg;
    wire sclk_rise = sclk & ~sclk_d_reg;
    wire sl_rise  = sload & ~sload_d_reg;
    wire sl_fall  = ~sload & sload_d_reg;
    wire [12:0] shift_next = {shift_reg[11:0], sdata};
    wire mr_all   = mr_pin | ctrl_reg[`SDC_CTRL_MR];
    wire ref_sel  = refsel ? xtal_s : alt_s;
    wire ref_tick = ref_sel & ~ref_d_reg;
    // bypass polarity unknown, high means pll
    wire bypass   = ~bypass_p ^ ctrl_reg[`SDC_CTRL_BYPASS];
    wire vco_tick = 1'b1;
    wire div_tick = bypass ? ref_tick : vco_tick;
    wire div_clk;

    // loader mode, in status so software can see a pending transfer
    localparam MODE_PAR  = 2'h0;
    localparam MODE_SER  = 2'h1;
    localparam MODE_XFER = 2'h2;
    localparam MODE_HELD = 2'h3;
    reg  [1:0] mode_reg;
    reg  [1:0] mode_next;

    always @* begin
        mode_next = mode_reg;
        if (!pl_n) begin
            mode_next = MODE_PAR;
        end else begin
            case (mode_reg)
                MODE_PAR:  mode_next = sload ? MODE_XFER : MODE_SER;
                MODE_SER:  mode_next = sl_rise ? MODE_XFER : MODE_SER;
                MODE_XFER: mode_next = sl_fall ? MODE_HELD : MODE_XFER;
                MODE_HELD: mode_next = sl_rise ? MODE_XFER : MODE_HELD;
                default:   mode_next = MODE_PAR;
            endcase
        end
    end

    always @(posedge sys_clk_in) begin
        if (rst_in) begin
            mode_reg <= MODE_PAR;
        end else if (clk_en_in) begin
            mode_reg <= mode_next;
        end
    end

    always @(posedge sys_clk_in) begin
        if (rst_in) begin
            pl_n_d_reg  <= 1'b0;
            sclk_d_reg  <= 1'b0;
            sload_d_reg <= 1'b0;
            shift_reg   <= 13'h0000;
            cfg_reg     <= 13'h0000;
            ref_d_reg   <= 1'b0;
        end else if (clk_en_in) begin
            pl_n_d_reg  <= pl_n;
            sclk_d_reg  <= sclk;
            sload_d_reg <= sload;
            ref_d_reg   <= ref_sel;
            if (!pl_n) begin
                cfg_reg <= {cfg_reg[12:11], n_pin, m_pin};
            end else if (pl_rise) begin
                cfg_reg <= {cfg_reg[12:11], n_pin, m_pin};
            end else begin
                if (sclk_rise && !sload) begin
                    shift_reg <= shift_next;
                end
                if (sclk_rise && sload) begin
                    shift_reg <= shift_next;
                    cfg_reg   <= shift_next;
                end else if (sl_rise) begin
                    cfg_reg <= shift_reg;
                end
            end
        end
    end

    always @(posedge sys_clk_in) begin
        if (rst_in) begin
            fb_cnt_reg <= 9'h000;
            fb_out_reg <= 1'b0;
        end else if (clk_en_in) begin
            if (mr_all) begin
                fb_cnt_reg <= 9'h000;
                fb_out_reg <= 1'b0;
            end else if (vco_tick) begin
                if (fb_cnt_reg + 9'h001 >= cfg_reg[`SDC_M_MSB:`SDC_M_LSB]) begin
                    fb_cnt_reg <= 9'h000;
                    fb_out_reg <= ~fb_out_reg;
                end else begin
                    fb_cnt_reg <= fb_cnt_reg + 9'h001;
                end
            end
        end
    end

    sdc_divider u_div (
        .sys_clk_in (sys_clk_in),
        .clk_en_in  (clk_en_in),
        .rst_in     (rst_in),
        .hold_in    (mr_all),
        .tick_in    (div_tick),
        .code_in    (cfg_reg[`SDC_N_MSB:`SDC_N_LSB]),
        .div_out    (div_clk)
    );

    always @(posedge sys_clk_in) begin
        if (rst_in) begin
            synth_out0_true_out <= 1'b0;
            synth_out0_comp_out <= 1'b1;
            synth_out1_true_out <= 1'b0;
            synth_out1_comp_out <= 1'b1;
            crystal_drive_output_out <= 1'b0;
            diag_out            <= 1'b0;
            feedback_divide_out <= 9'h000;
            output_divide_out   <= 2'h0;
            diag_select_msb_out <= 1'b0;
            diag_select_lsb_out <= 1'b0;
        end else if (clk_en_in) begin
            synth_out0_true_out <= ~mr_all & div_clk;
            synth_out0_comp_out <= ~(~mr_all & div_clk);
            synth_out1_true_out <= ~mr_all & div_clk;
            synth_out1_comp_out <= ~(~mr_all & div_clk);
            crystal_drive_output_out <= ~xtal_s;
            feedback_divide_out <= cfg_reg[`SDC_M_MSB:`SDC_M_LSB];
            output_divide_out   <= cfg_reg[`SDC_N_MSB:`SDC_N_LSB];
            diag_select_msb_out <= cfg_reg[`SDC_T_MSB];
            diag_select_lsb_out <= cfg_reg[`SDC_T_LSB];
            if (!pl_n) begin
                diag_out <= 1'b0;
            end else begin
                case (cfg_reg[`SDC_T_MSB:`SDC_T_LSB])
                    `SDC_DIAG_LOW:   diag_out <= 1'b0;
                    `SDC_DIAG_SDATA: diag_out <= sdata;
                    `SDC_DIAG_FB:    diag_out <= fb_out_reg;
                    `SDC_DIAG_CLK:   diag_out <= div_clk;
                    default:         diag_out <= 1'b0;
                endcase
            end
        end
    end

    // ahb-lite slave: zero wait states, always okay
    // read data is taken in the address phase: a read right after a write sees the old value
    reg        ap_valid_reg;
    reg        ap_write_reg;
    reg [7:0]  ap_addr_reg;
    wire       ap_take = hsel_in & htrans_in[1] & hready_in;
    reg [31:0] rd_mux;

    always @* begin
        rd_mux = 32'h0000_0000;
        case (haddr_in)
            `SDC_CTRL_OFS:   rd_mux = ctrl_reg;
            `SDC_STATUS_OFS: rd_mux = {25'h0, mode_reg, fb_out_reg, div_clk, mr_all, sload, pl_n};
            `SDC_CFG_OFS:    rd_mux = {19'h0, cfg_reg};
            `SDC_SHIFT_OFS:  rd_mux = {19'h0, shift_reg};
            default:         rd_mux = 32'h0000_0000;
        endcase
    end

    always @(posedge sys_clk_in) begin
        if (rst_in) begin
            ap_valid_reg  <= 1'b0;
            ap_write_reg  <= 1'b0;
            ap_addr_reg   <= 8'h00;
            ctrl_reg      <= `SDC_CTRL_RESET;
            hrdata_out    <= 32'h0000_0000;
            hreadyout_out <= 1'b1;
            hresp_out     <= 1'b0;
        end else if (clk_en_in) begin
            if (hready_in) begin
                ap_valid_reg <= ap_take;
                ap_write_reg <= hwrite_in;
                ap_addr_reg  <= haddr_in;
            end
            if (ap_valid_reg && ap_write_reg && ap_addr_reg == `SDC_CTRL_OFS) begin
                ctrl_reg <= {29'h0, hwdata_in[2:0]};
            end
            // read data registered at address phase, stands in data phase
            if (ap_take && !hwrite_in) begin
                hrdata_out <= rd_mux;
            end
        end
    end
endmodule

// *** tb/sdc_checker.sv ***
// Purpose: pin-level relations of the configuration loader
// Assumes: clk_en_in high; a pin reaches the outputs within 4 cycles
// Notes:   windows of 5..6 cycles cover the two-flop sync
`timescale 1ns/1ps
module sdc_checker (
    input wire logic       sys_clk_in, rst_in, divider_reset_in, serial_data_in,
    input wire logic       parallel_latch_strobe_n_in, serial_load_in, hreadyout_out,
    input wire logic       hresp_out, diag_out, diag_select_msb_out, diag_select_lsb_out,
    input wire logic       synth_out0_true_out, synth_out0_comp_out,
    input wire logic       synth_out1_true_out, synth_out1_comp_out,
    input wire logic [8:0] feedback_divide_inputs_in, feedback_divide_out,
    input wire logic [1:0] output_divide_inputs_in, output_divide_out
);
    default clocking @(posedge sys_clk_in);
    endclocking
    default disable iff (rst_in);
    wire        s_n = parallel_latch_strobe_n_in;
    wire [1:0]  tsel = {diag_select_msb_out, diag_select_lsb_out};
    wire [10:0] cfg = {output_divide_out, feedback_divide_out};
    reset_outs_a: assert property (
        divider_reset_in [*6] |-> {synth_out0_true_out, synth_out0_comp_out,
        synth_out1_true_out, synth_out1_comp_out} == 4'b0101) else $error("outs not reset");
    comp_pair_a: assert property (
        synth_out0_comp_out != synth_out0_true_out && synth_out1_comp_out != synth_out1_true_out)
        else $error("complement wrong");
    par_pass_a: assert property (
        (!s_n && $stable(feedback_divide_inputs_in) && $stable(output_divide_inputs_in)) [*6]
        |-> cfg == {output_divide_inputs_in, feedback_divide_inputs_in}) else $error("no pass");
    diag_par_a: assert property (!s_n [*5] |-> !diag_out) else $error("diag not low");
    cfg_hold_a: assert property ((s_n && !serial_load_in) [*6] |=> $stable(cfg))
        else $error("config moved");
    diag_low_a: assert property ((s_n && tsel == 2'b00) [*6] |-> !diag_out)
        else $error("diag code 0");
    diag_data_a: assert property (
        (s_n && tsel == 2'b01 && $stable(serial_data_in)) [*6] |-> diag_out == serial_data_in)
        else $error("diag code 1");
    diag_clk_a: assert property (
        (s_n && !divider_reset_in && tsel == 2'b11) [*6] |-> diag_out == synth_out0_true_out)
        else $error("diag code 3");
    bus_okay_a: assert property (hreadyout_out && !hresp_out) else $error("bus not okay");
endmodule
bind sdc_top sdc_checker i_sdc_checker (.sys_clk_in(sys_clk_in), .rst_in(rst_in),
    .divider_reset_in(divider_reset_in), .serial_data_in(serial_data_in),
    .parallel_latch_strobe_n_in(parallel_latch_strobe_n_in), .serial_load_in(serial_load_in),
    .hreadyout_out(hreadyout_out), .hresp_out(hresp_out), .diag_out(diag_out),
    .diag_select_msb_out(diag_select_msb_out), .diag_select_lsb_out(diag_select_lsb_out),
    .synth_out0_true_out(synth_out0_true_out), .synth_out0_comp_out(synth_out0_comp_out),
    .synth_out1_true_out(synth_out1_true_out), .synth_out1_comp_out(synth_out1_comp_out),
    .feedback_divide_inputs_in(feedback_divide_inputs_in),
    .feedback_divide_out(feedback_divide_out), .output_divide_out(output_divide_out),
    .output_divide_inputs_in(output_divide_inputs_in));

// *** tb/sdc_host_model.sv ***
// Purpose: controller driving the configuration pins
// Assumes: tasks are entered just after a clock edge
// Notes:   each level stands at least 6 cycles, three times the pin sync depth
`timescale 1ns/1ps
module sdc_host_model (
    // timing reference
    input  wire logic  clk_in,
    // configuration pins
    output logic       strobe_n_out,
    output logic       sclk_out,
    output logic       sdata_out,
    output logic       sload_out,
    output logic [8:0] fb_out,
    output logic [1:0] nd_out
);
    initial {strobe_n_out, sclk_out, sdata_out, sload_out, fb_out, nd_out} = 15'h0000;
    task hold6;
        repeat (6) @(posedge clk_in);
    endtask
    task set_pins(input logic [8:0] m, input logic [1:0] n);
        fb_out <= m;
        nd_out <= n;
        hold6;
        hold6;
    endtask
    task par_load(input logic [8:0] m, input logic [1:0] n);
        strobe_n_out <= 1'b0;
        set_pins(m, n);
        strobe_n_out <= 1'b1;
        hold6;
    endtask
    task ser_load(input logic [12:0] w, input logic hold);
        integer i;
        strobe_n_out <= 1'b1;
        sload_out <= hold;
        hold6;
        for (i = 12; i >= 0; i--) begin
            sdata_out <= w[i];
            hold6;
            sclk_out <= 1'b1;
            hold6;
            sclk_out <= 1'b0;
        end
        // released data falls to its pulldown
        sdata_out <= 1'b0;
        if (!hold) begin
            hold6;
            sload_out <= 1'b1;
            hold6;
            sload_out <= 1'b0;
        end
        hold6;
    endtask
    task end_hold;
        sload_out <= 1'b0;
        hold6;
    endtask
endmodule

// *** tb/tb_top.sv ***
// Purpose: directed bench for the configuration loader
// Assumes: outputs settle within 4 cycles of a pin change
// Notes:   divider counts allow one period of slack at window edges
`timescale 1ns/1ps
`include "sdc_regs.vh"
module tb_top;
    logic        sys_clk_in = 1'b0, rst_in = 1'b1, mr = 1'b0, xtal = 1'b0, hsel = 1'b0;
    logic        alt = 1'b0, refsel = 1'b1, byp = 1'b1;
    logic        hwrite = 1'b0, prev;
    logic [1:0]  htrans = 2'h0;
    logic [7:0]  haddr = 8'h00;
    logic [31:0] hwdata = 32'h0, rd;
    wire         stb_n, sclk, sdat, sld, hrdy, hresp, o0t, o0c, o1t, o1c, diag, tm, tl, xdrv;
    wire [8:0]   m_pin, m_o;
    wire [1:0]   n_pin, n_o;
    wire [31:0]  hrdata;
    integer      mismatches = 0, num_checks = 0, k, r, h;
    always #50 sys_clk_in = ~sys_clk_in;
    always @(posedge sys_clk_in) xtal <= ~xtal;
    always @(posedge sys_clk_in) if (xtal) alt <= ~alt;
    sdc_host_model i_sdc_host_model (.clk_in(sys_clk_in), .strobe_n_out(stb_n),
        .sclk_out(sclk), .sdata_out(sdat), .sload_out(sld), .fb_out(m_pin), .nd_out(n_pin));
    sdc_top i_sdc_top (.sys_clk_in(sys_clk_in), .clk_en_in(1'b1), .rst_in(rst_in),
        .divider_reset_in(mr), .parallel_latch_strobe_n_in(stb_n),
        .feedback_divide_inputs_in(m_pin), .output_divide_inputs_in(n_pin),
        .serial_clock_in(sclk), .serial_data_in(sdat), .serial_load_in(sld),
        .reference_source_select_in(refsel), .pll_bypass_select_in(byp),
        .crystal_input_in(xtal), .alt_reference_in(alt), .hsel_in(hsel), .haddr_in(haddr),
        .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(3'h2), .hwdata_in(hwdata),
        .hready_in(hrdy), .hrdata_out(hrdata), .hreadyout_out(hrdy), .hresp_out(hresp),
        .synth_out0_true_out(o0t), .synth_out0_comp_out(o0c), .synth_out1_true_out(o1t),
        .synth_out1_comp_out(o1c), .crystal_drive_output_out(xdrv), .diag_out(diag),
        .feedback_divide_out(m_o), .output_divide_out(n_o), .diag_select_msb_out(tm),
        .diag_select_lsb_out(tl));
    task chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("wrong value at %0t ns: got %h expected %h", $time, got, exp);
        end
    endtask
    task ahb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk_in);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= a;
        hwrite <= wr;
        @(posedge sys_clk_in);
        while (hrdy !== 1'b1) @(posedge sys_clk_in);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        @(posedge sys_clk_in);
        while (hrdy !== 1'b1) @(posedge sys_clk_in);
        rd = hrdata;
    endtask
    // counts rising edges and high cycles of output 0
    task measure(input integer n);
        r = 0;
        h = 0;
        prev = o0t;
        repeat (n) begin
            @(posedge sys_clk_in);
            #1;
            r += (o0t === 1'b1 && prev === 1'b0);
            h += (o0t === 1'b1);
            prev = o0t;
        end
    endtask
    task close_out;
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    initial begin
        #2000000;
        mismatches++;
        close_out;
    end
    initial begin
        repeat (5) @(posedge sys_clk_in);
        rst_in <= 1'b0;
        ahb(1'b0, `SDC_CTRL_OFS, 32'h0);
        chk(rd, `SDC_CTRL_RESET);
        ahb(1'b1, 8'h40, 32'hffff_ffff);
        ahb(1'b0, 8'h40, 32'h0);
        chk(rd, 32'h0);
        chk({o0t, o0c, o1t, o1c}, 4'b0101);
        ahb(1'b1, `SDC_CTRL_OFS, 32'h0);
        ahb(1'b0, `SDC_CTRL_OFS, 32'h0);
        chk(rd, 32'h0);
        $display("test registers done");
        // m stays 25..28 to keep the loop in lock
        for (k = 0; k < 4; k++) begin
            i_sdc_host_model.par_load(9'd25 + k[8:0], k[1:0]);
            ahb(1'b0, `SDC_CFG_OFS, 32'h0);
            chk(rd, {21'h0, k[1:0], 9'd25 + k[8:0]});
            measure(240);
            chk(r >= 240 / (3 + k) - 1 && r <= 240 / (3 + k) + 1, 1);
            chk(h >= 120 - (3 + k) && h <= 120 + (3 + k), 1);
        end
        i_sdc_host_model.set_pins(9'h1ff, 2'h3);
        chk({n_o, m_o}, {2'd3, 9'd28});
        byp <= 1'b0;
        repeat (8) @(posedge sys_clk_in);
        measure(240);
        chk(r >= 19 && r <= 21, 1);
        chk(xdrv, xtal);
        @(posedge sys_clk_in);
        refsel <= 1'b0;
        repeat (8) @(posedge sys_clk_in);
        measure(240);
        chk(r >= 9 && r <= 11, 1);
        @(posedge sys_clk_in);
        byp <= 1'b1;
        ahb(1'b1, `SDC_CTRL_OFS, 32'h4);
        repeat (8) @(posedge sys_clk_in);
        measure(240);
        chk(r >= 9 && r <= 11, 1);
        ahb(1'b1, `SDC_CTRL_OFS, 32'h0);
        refsel <= 1'b1;
        $display("test parallel done");
        for (k = 0; k < 4; k++) begin
            i_sdc_host_model.ser_load({k[1:0], 2'd2, 9'd27}, 1'b0);
            chk({tm, tl, n_o, m_o}, {k[1:0], 2'd2, 9'd27});
        end
        ahb(1'b0, `SDC_STATUS_OFS, 32'h0);
        chk(rd[6:5], 2'h3);
        mr <= 1'b1;
        repeat (10) @(posedge sys_clk_in);
        chk({o0t, o0c, o1t, o1c, tm, tl, n_o, m_o}, {4'b0101, 2'd3, 2'd2, 9'd27});
        mr <= 1'b0;
        measure(40);
        chk(r > 0, 1);
        $display("test serial and reset done");
        i_sdc_host_model.ser_load(13'h0a1b, 1'b1);
        chk({tm, tl, n_o, m_o}, 13'h0a1b);
        i_sdc_host_model.end_hold;
        i_sdc_host_model.set_pins(9'h000, 2'h0);
        chk({tm, tl, n_o, m_o}, 13'h0a1b);
        i_sdc_host_model.par_load(9'd30, 2'd1);
        chk({tm, tl, n_o, m_o}, {2'b01, 2'd1, 9'd30});
        $display("test pass-through done");
        close_out;
    end
endmodule
